// >>> pkg/prd_pkg.sv
package prd_pkg;
   localparam int MAG_W = 16;
   localparam int RAT_W = 9;
   localparam int DLY_W = 13;
   localparam int ADDR_W = 12;
   localparam int CMP_W = MAG_W + RAT_W;

   typedef enum logic [1:0] {
      PRD_ROT_STD = 2'h0,
      PRD_ROT_REV = 2'h1,
      PRD_ROT_AUTO = 2'h2
   } prd_mode_t;

   // minimum phase voltage, volts
   localparam logic [MAG_W-1:0] VMIN_LO = 16'h0064;
   localparam logic [MAG_W-1:0] VMIN_HI = 16'h8CA0;
   localparam logic [MAG_W-1:0] VMIN_RST = 16'h07D0;
   // negative over positive ratio, hundredths
   localparam logic [RAT_W-1:0] RAT_LO = 9'h069;
   localparam logic [RAT_W-1:0] RAT_HI = 9'h1F4;
   localparam logic [RAT_W-1:0] RAT_RST = 9'h078;
   localparam logic [RAT_W-1:0] RAT_SCALE = 9'h064;
   // delay in time-base ticks, one tick per hundredth of a second
   localparam int TICK_MS = 10;
   localparam int DELAY_RST_MS = 5000;
   localparam logic [DLY_W-1:0] DLY_LO = 13'h000A;
   localparam logic [DLY_W-1:0] DLY_HI = 13'h1770;
   localparam logic [DLY_W-1:0] DLY_RST = DLY_W'(DELAY_RST_MS / TICK_MS);

   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 12'h008;
   localparam int CARD_LSB = 5;
   localparam logic [CARD_LSB-1:0] OFS_MODE = 5'h00;
   localparam logic [CARD_LSB-1:0] OFS_VMIN = 5'h04;
   localparam logic [CARD_LSB-1:0] OFS_RATIO = 5'h08;
   localparam logic [CARD_LSB-1:0] OFS_DELAY = 5'h0C;
   localparam logic [CARD_LSB-1:0] OFS_STATE = 5'h10;
   localparam int ST_REV_BIT = 0;
   localparam int ST_RUN_BIT = 1;
   localparam int ST_VOK_BIT = 2;
endpackage

// >>> pkg/prd_unit_if.sv
interface prd_unit_if;
   prd_pkg::prd_mode_t mode;
   logic [prd_pkg::MAG_W-1:0] vMin;
   logic [prd_pkg::RAT_W-1:0] ratio;
   logic [prd_pkg::DLY_W-1:0] delay;
   logic [2:0][prd_pkg::MAG_W-1:0] phaseMag;
   logic [prd_pkg::MAG_W-1:0] seqPos;
   logic [prd_pkg::MAG_W-1:0] seqNeg;
   logic tick;
   logic run;
   logic voltsOk;
   logic expire;
   logic reversed;
   logic flip;

   modport unit (
      input mode, vMin, ratio, phaseMag, seqPos, seqNeg, expire,
      output run, voltsOk, reversed, flip
   );
   modport timer (
      input run, tick, delay,
      output expire
   );
endinterface

// >>> design/prd_delay_timer.sv
module prd_delay_timer (
   input wire logic clock,
   input wire logic rst,
   prd_unit_if.timer bus
);
   logic [prd_pkg::DLY_W-1:0] cntQ;
   logic [prd_pkg::DLY_W:0] cntInc;
   logic lastTick;

   assign cntInc = {1'b0, cntQ} + 14'h0001;
   assign lastTick = bus.run & bus.tick & (cntInc >= {1'b0, bus.delay});

   // counts front-end ticks only; ticks carry the time base
   always_ff @(posedge clock) begin
      if (rst) begin
         cntQ <= '0;
      end else if (!bus.run) begin
         cntQ <= '0;
      end else if (lastTick) begin
         cntQ <= '0;
      end else if (bus.tick) begin
         cntQ <= cntInc[prd_pkg::DLY_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bus.expire <= 1'b0;
      end else begin
         bus.expire <= lastTick;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence sqLastTick;
      bus.run && bus.tick && (cntInc >= {1'b0, bus.delay});
   endsequence

   AST_EXPIRE_AT_DELAY: assert property (sqLastTick |=> bus.expire && cntQ == '0)
      else $error("delay did not expire on its last tick");
   AST_NO_EARLY_EXPIRE: assert property (bus.run && bus.tick && !lastTick
      |=> !bus.expire && cntQ == $past(cntQ) + 1'b1)
      else $error("delay expired early");
   AST_IDLE_CLEARS: assert property (!bus.run |=> cntQ == '0)
      else $error("timer not cleared while idle");
endmodule

// >>> design/prd_unit.sv
module prd_unit (
   input wire logic clock,
   input wire logic rst,
   prd_unit_if.unit bus
);
   logic [2:0] above;
   logic [prd_pkg::CMP_W-1:0] negScaled;
   logic [prd_pkg::CMP_W-1:0] posScaled;
   logic ratioHigh;
   logic autoMode;

   for (genvar p = 0; p < 3; p++) begin : g_phase
      assign above[p] = bus.phaseMag[p] > bus.vMin;
   end

   // scaled compare avoids a divider: v2 * 100 against limit * v1
   assign negScaled = prd_pkg::CMP_W'(bus.seqNeg) * prd_pkg::CMP_W'(prd_pkg::RAT_SCALE);
   assign posScaled = prd_pkg::CMP_W'(bus.seqPos) * prd_pkg::CMP_W'(bus.ratio);
   assign ratioHigh = negScaled > posScaled;
   assign autoMode = bus.mode == prd_pkg::PRD_ROT_AUTO;
   assign bus.voltsOk = &above;
   assign bus.run = autoMode & bus.voltsOk & ratioHigh;

   always_ff @(posedge clock) begin
      if (rst) begin
         bus.reversed <= 1'b0;
      end else begin
         unique case (bus.mode)
            prd_pkg::PRD_ROT_STD: bus.reversed <= 1'b0;
            prd_pkg::PRD_ROT_REV: bus.reversed <= 1'b1;
            prd_pkg::PRD_ROT_AUTO: begin
               if (bus.expire) begin
                  bus.reversed <= !bus.reversed;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bus.flip <= 1'b0;
      end else begin
         bus.flip <= autoMode & bus.expire;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_FORCE_STD: assert property (bus.mode == prd_pkg::PRD_ROT_STD |=> !bus.reversed)
      else $error("standard code did not force standard rotation");
   AST_FORCE_REV: assert property (bus.mode == prd_pkg::PRD_ROT_REV |=> bus.reversed)
      else $error("reversed code did not force reversed rotation");
   AST_INVERT: assert property (autoMode && bus.expire |=> bus.reversed != $past(bus.reversed))
      else $error("expiry did not invert rotation");
   AST_HOLD_AUTO: assert property (autoMode && !bus.expire |=> $stable(bus.reversed))
      else $error("rotation changed without expiry");
   AST_LOW_PHASE: assert property (bus.phaseMag[0] <= bus.vMin ||
      bus.phaseMag[1] <= bus.vMin || bus.phaseMag[2] <= bus.vMin |-> !bus.run)
      else $error("evaluation ran with a low phase");
   AST_RATIO_RUN: assert property (autoMode && (&above) && ratioHigh |-> bus.run)
      else $error("ratio above limit did not start the timer");
endmodule

// >>> design/prd_top.sv
// Contract
// - mode 0 standard, 1 reversed, 2 automatic; automatic after reset
// - a fixed code sets the rotation in force, no evaluation
// - only automatic mode derives rotation, from sequence magnitudes
// - evaluate only while every phase exceeds the minimum voltage setting
// - negative over positive ratio above limit starts the delay timer
// - timer expiry inverts the rotation in force
// - two exclusive outputs show standard or reversed rotation
// - one independent unit per measurement card
// - defaults settle or swap rotation after five seconds
//
// The register offsets and the APB register port were chosen for this implementation.
module prd_top #(
   parameter int NUM_CARDS = 2
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [prd_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tick,
   input wire logic [NUM_CARDS*3*prd_pkg::MAG_W-1:0] phaseMag,
   input wire logic [NUM_CARDS*prd_pkg::MAG_W-1:0] seqPos,
   input wire logic [NUM_CARDS*prd_pkg::MAG_W-1:0] seqNeg,
   output logic [NUM_CARDS-1:0] standardRotationInd,
   output logic [NUM_CARDS-1:0] reversedRotationInd,
   output logic irq
);
   localparam int N = NUM_CARDS;
   localparam int MW = prd_pkg::MAG_W;
   localparam int CL = prd_pkg::CARD_LSB;

   prd_pkg::prd_mode_t modeQ [N];
   logic [MW-1:0] vMinQ [N];
   logic [prd_pkg::RAT_W-1:0] ratioQ [N];
   logic [prd_pkg::DLY_W-1:0] delayQ [N];
   logic [N-1:0] irqStatusQ;
   logic [N-1:0] irqEnableQ;
   logic [N-1:0] unitRev;
   logic [N-1:0] unitRun;
   logic [N-1:0] unitVok;
   logic [N-1:0] unitFlip;

   logic access;
   logic commit;
   logic addrOk;
   logic valOk;
   logic roHit;
   logic [31:0] rdMux;
   logic wrStrobe;
   logic globalWr;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic cardHit(input logic [prd_pkg::ADDR_W-1:0] a, input int idx);
      logic [prd_pkg::ADDR_W-CL-1:0] sel;
      sel = (prd_pkg::ADDR_W-CL)'(idx + 1);
      return a[prd_pkg::ADDR_W-1:CL] == sel;
   endfunction

   function automatic logic inRange(input logic [31:0] v, input logic [31:0] lo,
                                    input logic [31:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // address decode and read mux
   always_comb begin
      addrOk = 1'b0;
      valOk = 1'b1;
      roHit = 1'b0;
      rdMux = '0;
      globalWr = 1'b0;
      if (paddr == prd_pkg::OFS_IRQ_STATUS) begin
         addrOk = 1'b1;
         roHit = 1'b1;
         rdMux = 32'(irqStatusQ);
      end else if (paddr == prd_pkg::OFS_IRQ_ENABLE) begin
         addrOk = 1'b1;
         globalWr = 1'b1;
         rdMux = 32'(irqEnableQ);
      end else if (paddr == prd_pkg::OFS_IRQ_CLEAR) begin
         addrOk = 1'b1;
         globalWr = 1'b1;
      end
      for (int i = 0; i < N; i++) begin
         if (cardHit(paddr, i)) begin
            unique case (paddr[CL-1:0])
               prd_pkg::OFS_MODE: begin
                  addrOk = 1'b1;
                  rdMux = 32'(modeQ[i]);
                  // only the three defined codes are accepted
                  valOk = inRange(pwdata, 32'h0000_0000, 32'(prd_pkg::PRD_ROT_AUTO));
               end
               prd_pkg::OFS_VMIN: begin
                  addrOk = 1'b1;
                  rdMux = 32'(vMinQ[i]);
                  valOk = inRange(pwdata, 32'(prd_pkg::VMIN_LO), 32'(prd_pkg::VMIN_HI));
               end
               prd_pkg::OFS_RATIO: begin
                  addrOk = 1'b1;
                  rdMux = 32'(ratioQ[i]);
                  valOk = inRange(pwdata, 32'(prd_pkg::RAT_LO), 32'(prd_pkg::RAT_HI));
               end
               prd_pkg::OFS_DELAY: begin
                  addrOk = 1'b1;
                  rdMux = 32'(delayQ[i]);
                  valOk = inRange(pwdata, 32'(prd_pkg::DLY_LO), 32'(prd_pkg::DLY_HI));
               end
               prd_pkg::OFS_STATE: begin
                  addrOk = 1'b1;
                  roHit = 1'b1;
                  rdMux[prd_pkg::ST_REV_BIT] = unitRev[i];
                  rdMux[prd_pkg::ST_RUN_BIT] = unitRun[i];
                  rdMux[prd_pkg::ST_VOK_BIT] = unitVok[i];
               end
               default: addrOk = 1'b0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, effect at the edge pready is sampled high
   assign access = psel & penable;
   assign commit = access & pready;
   assign wrStrobe = commit & pwrite & addrOk & valOk & !roHit;

   always_ff @(posedge clock) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= access & !pready;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (access & !pready) begin
         prdata <= (pwrite || !addrOk) ? 32'h0000_0000 : rdMux;
         // out-of-range settings and read-only targets are refused
         pslverr <= !addrOk | (pwrite & (!valOk | roHit));
      end else begin
         prdata <= '0;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-card settings
   for (genvar i = 0; i < N; i++) begin : g_set
      always_ff @(posedge clock) begin
         if (rst) begin
            modeQ[i] <= prd_pkg::PRD_ROT_AUTO;
            vMinQ[i] <= prd_pkg::VMIN_RST;
            ratioQ[i] <= prd_pkg::RAT_RST;
            delayQ[i] <= prd_pkg::DLY_RST;
         end else if (wrStrobe && cardHit(paddr, i)) begin
            unique case (paddr[CL-1:0])
               prd_pkg::OFS_MODE: modeQ[i] <= prd_pkg::prd_mode_t'(pwdata[1:0]);
               prd_pkg::OFS_VMIN: vMinQ[i] <= pwdata[MW-1:0];
               prd_pkg::OFS_RATIO: ratioQ[i] <= pwdata[prd_pkg::RAT_W-1:0];
               prd_pkg::OFS_DELAY: delayQ[i] <= pwdata[prd_pkg::DLY_W-1:0];
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status: a flip in the clearing cycle stays set
   always_ff @(posedge clock) begin
      if (rst) begin
         irqStatusQ <= '0;
      end else if (commit && pwrite && paddr == prd_pkg::OFS_IRQ_CLEAR) begin
         irqStatusQ <= (irqStatusQ & ~pwdata[N-1:0]) | unitFlip;
      end else begin
         irqStatusQ <= irqStatusQ | unitFlip;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irqEnableQ <= '0;
      end else if (commit && pwrite && globalWr && paddr == prd_pkg::OFS_IRQ_ENABLE) begin
         irqEnableQ <= pwdata[N-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatusQ & irqEnableQ);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // one detection unit and delay timer per card
   for (genvar i = 0; i < N; i++) begin : g_card
      prd_unit_if cardIf ();

      assign cardIf.mode = modeQ[i];
      assign cardIf.vMin = vMinQ[i];
      assign cardIf.ratio = ratioQ[i];
      assign cardIf.delay = delayQ[i];
      // unsigned magnitudes on one scale, phase a in the low slice
      assign cardIf.phaseMag = phaseMag[i*3*MW +: 3*MW];
      assign cardIf.seqPos = seqPos[i*MW +: MW];
      assign cardIf.seqNeg = seqNeg[i*MW +: MW];
      assign cardIf.tick = tick;
      assign unitRev[i] = cardIf.reversed;
      assign unitRun[i] = cardIf.run;
      assign unitVok[i] = cardIf.voltsOk;
      assign unitFlip[i] = cardIf.flip;

      prd_unit u_unit (
         .clock(clock),
         .rst(rst),
         .bus(cardIf.unit)
      );

      prd_delay_timer u_timer (
         .clock(clock),
         .rst(rst),
         .bus(cardIf.timer)
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // indications mirror the rotation in force, never both
   always_ff @(posedge clock) begin
      if (rst) begin
         standardRotationInd <= '1;
         reversedRotationInd <= '0;
      end else begin
         standardRotationInd <= ~unitRev;
         reversedRotationInd <= unitRev;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence sqAccessWait;
      psel && penable && !pready;
   endsequence

   sequence sqAccessDone;
      psel && penable && pready;
   endsequence

   AST_IND_EXCL: assert property ((standardRotationInd ^ reversedRotationInd) == '1)
      else $error("rotation indications not exclusive");
   AST_IND_FOLLOW: assert property (##1 reversedRotationInd == $past(unitRev))
      else $error("reversed indication lags the unit");
   AST_RESET_AUTO: assert property ($past(rst) |-> modeQ[0] == prd_pkg::PRD_ROT_AUTO)
      else $error("mode not automatic after reset");
   AST_APB_ONE_WAIT: assert property (sqAccessWait |=> sqAccessDone or !psel)
      else $error("apb answer not after one wait state");
   AST_IRQ_LEVEL: assert property (##1 irq == $past(|(irqStatusQ & irqEnableQ)))
      else $error("interrupt does not track enabled status");
   AST_SET_WINS: assert property (|unitFlip |=> (irqStatusQ & $past(unitFlip)) == $past(unitFlip))
      else $error("status event lost");

   ////////////////////////////////////////////////////////////////////////
   // bus, settings and status guards
   sequence sqSetup;
      psel && !penable;
   endsequence

   sequence sqWriteDone;
      commit && pwrite;
   endsequence

   sequence sqReadDone;
      commit && !pwrite;
   endsequence

   sequence sqLastCardWrite;
      commit && pwrite && cardHit(paddr, N - 1);
   endsequence

   AST_SETUP_NO_READY: assert property (sqSetup |=> !pready)
      else $error("answer in first access cycle");

   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held too long");

   AST_IDLE_QUIET: assert property (!pready |-> prdata == '0 && !pslverr)
      else $error("data or error outside an answer");

   AST_UNMAPPED_READ: assert property (sqReadDone ##0 !addrOk |-> pslverr && prdata == '0)
      else $error("unmapped read not refused");

   AST_RO_WRITE_ERR: assert property (sqWriteDone ##0 paddr == prd_pkg::OFS_IRQ_STATUS
      |-> pslverr)
      else $error("status write not refused");

   AST_REFUSE_ERR: assert property (sqWriteDone ##0 !valOk |-> pslverr)
      else $error("out-of-range setting accepted");

   AST_REFUSE_KEEPS: assert property (sqWriteDone ##0 pslverr |=> $stable(modeQ[0])
      && $stable(vMinQ[0]) && $stable(ratioQ[0]) && $stable(delayQ[0]))
      else $error("refused write changed a setting");

   AST_RATIO_LANDS: assert property (sqLastCardWrite ##0
      paddr[CL-1:0] == prd_pkg::OFS_RATIO && !pslverr
      |=> ratioQ[N-1] == $past(pwdata[prd_pkg::RAT_W-1:0]))
      else $error("ratio write did not land");

   AST_DELAY_LANDS: assert property (sqLastCardWrite ##0
      paddr[CL-1:0] == prd_pkg::OFS_DELAY && !pslverr
      |=> delayQ[N-1] == $past(pwdata[prd_pkg::DLY_W-1:0]))
      else $error("delay write did not land");

   AST_MODE_LEGAL: assert property (modeQ[N-1] <= prd_pkg::PRD_ROT_AUTO)
      else $error("illegal rotation code stored");

   AST_RESET_VMIN: assert property ($past(rst) |-> vMinQ[N-1] == prd_pkg::VMIN_RST)
      else $error("threshold not at reset value");

   AST_RESET_RATIO: assert property ($past(rst) |-> ratioQ[N-1] == prd_pkg::RAT_RST)
      else $error("ratio not at reset value");

   AST_RESET_DELAY: assert property ($past(rst) |-> delayQ[N-1] == prd_pkg::DLY_RST)
      else $error("delay not at reset value");

   AST_CARD_APART: assert property (sqLastCardWrite ##0 N > 1
      |=> $stable(modeQ[0]) && $stable(vMinQ[0]) && $stable(delayQ[0]))
      else $error("write to one card changed another");

   AST_FIXED_NO_FLIP: assert property (modeQ[N-1] != prd_pkg::PRD_ROT_AUTO
      |=> !unitFlip[N-1])
      else $error("fixed rotation code inverted");

   AST_CLEAR_BITS: assert property (sqWriteDone ##0 paddr == prd_pkg::OFS_IRQ_CLEAR
      |=> (irqStatusQ & $past(pwdata[N-1:0] & ~unitFlip)) == '0)
      else $error("cleared status bit still set");

   AST_STATUS_STICKY: assert property (!(commit && pwrite && paddr == prd_pkg::OFS_IRQ_CLEAR)
      |=> (irqStatusQ & $past(irqStatusQ)) == $past(irqStatusQ))
      else $error("status bit dropped without clear");

   AST_ENABLE_WRITE: assert property (sqWriteDone ##0 paddr == prd_pkg::OFS_IRQ_ENABLE
      |=> irqEnableQ == $past(pwdata[N-1:0]))
      else $error("enable write did not land");

   AST_IRQ_MASKED: assert property (irqEnableQ == '0 |=> !irq)
      else $error("interrupt raised while masked");

   AST_STD_FOLLOW: assert property (##1 standardRotationInd == ~$past(unitRev))
      else $error("standard indication lags");
endmodule

// >>> test/prd_front_end_model.sv
module prd_front_end_model #(
   parameter int NC = 2,
   parameter int TP = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [NC-1:0] actRev,
   input wire logic [NC-1:0] inForceRev,
   input wire logic [8:0] ratioPct,
   output logic [NC*16-1:0] seqPos,
   output logic [NC*16-1:0] seqNeg,
   output logic tick
);
   timeunit 1ns;
   timeprecision 100ps;
   int tickCnt_q;
   logic [15:0] big;
   assign big = 16'(ratioPct) * 16'h000A;
   ////////////////////////////////////////////////////////////////////////
   // time base: one pulse every TP clocks, shortened from the real rate
   always_ff @(posedge clock) begin
      if (rst || tickCnt_q == TP - 1) begin
         tickCnt_q <= 0;
      end else begin
         tickCnt_q <= tickCnt_q + 1;
      end
      tick <= !rst && tickCnt_q == TP - 1;
   end
   ////////////////////////////////////////////////////////////////////////
   // sequence split is computed against the rotation the device assumes,
   // so a wrong assumption shows as a large negative sequence
   always_ff @(posedge clock) begin
      for (int c = 0; c < NC; c++) begin
         if (actRev[c] ^ inForceRev[c]) begin
            seqPos[c*16+:16] <= 16'h03E8;
            seqNeg[c*16+:16] <= big;
         end else begin
            seqPos[c*16+:16] <= big;
            seqNeg[c*16+:16] <= 16'h03E8;
         end
      end
   end
endmodule

// >>> test/testbench.sv
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, exp, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic rd; logic [31:0] data; logic err;} prd_note_t;
   logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, seed = 32'h8EC461CE;
   logic pready, pslverr, tick, irq;
   logic [95:0] phaseMag = '0;
   logic [31:0] seqPos, seqNeg;
   logic [1:0] stdInd, revInd, actRev = 2'h0;
   logic [8:0] ratioPct = 9'h0C8;
   int n_errors = 0, check_count = 0;
   prd_note_t notes[$];
   prd_note_t nt;
   always #5 clock = ~clock;
   prd_top #(.NUM_CARDS(2)) u_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tick(tick), .phaseMag(phaseMag), .seqPos(seqPos), .seqNeg(seqNeg),
      .standardRotationInd(stdInd), .reversedRotationInd(revInd), .irq(irq));
   prd_front_end_model #(.NC(2), .TP(4)) u_fe (.clock(clock), .rst(rst), .actRev(actRev),
      .inForceRev(revInd), .ratioPct(ratioPct), .seqPos(seqPos), .seqNeg(seqNeg), .tick(tick));
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [11:0] ca(input int c, input logic [4:0] ofs);
      return 12'(32 * (c + 1)) + 12'(ofs);
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] expD, input logic expErr);
      int n;
      prd_note_t note;
      note.rd = !w;
      note.data = expD;
      note.err = expErr;
      notes.push_back(note);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         n_errors++;
         finish_test();
      end
      @(posedge clock);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d, 32'h0, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
      apb(1'b0, a, 32'h0, d, e);
   endtask
   // counts ticks until the card shows the expected rotation
   task automatic wait_flip(input int c, input logic expRev, input int d);
      int n, t;
      n = 0;
      t = 0;
      while (revInd[c] !== expRev && n < 4000) begin
         @(posedge clock);
         n++;
         if (tick === 1'b1) t++;
      end
      if (n >= 4000) begin
         n_errors++;
         finish_test();
      end
      `CHK("flip ticks ok", 1'b1, 1'(t >= d && t <= d + 2))
      `CHK("exclusive ind", ~revInd, stdInd)
   endtask
   ////////////////////////////////////////////////////////////////////////
   // answer checker: oldest note against each completed transfer
   always @(posedge clock) begin
      if (pready === 1'b1) begin
         if (notes.size() == 0) begin
            `CHK("unexpected answer", 1'b0, 1'b1)
         end else begin
            nt = notes.pop_front();
            `CHK("apb err", nt.err, pslverr)
            if (nt.rd) `CHK("apb rdata", nt.data, prdata)
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      `CHK("std after reset", 2'h3, stdInd)
      `CHK("rev after reset", 2'h0, revInd)
      rd(ca(0, prd_pkg::OFS_MODE), 32'h2, 1'b0);
      rd(ca(1, prd_pkg::OFS_VMIN), 32'h7D0, 1'b0);
      rd(ca(0, prd_pkg::OFS_RATIO), 32'h78, 1'b0);
      rd(ca(1, prd_pkg::OFS_DELAY), 32'h1F4, 1'b0);
      rd(prd_pkg::OFS_IRQ_STATUS, 32'h0, 1'b0);
      wr(ca(0, prd_pkg::OFS_MODE), 32'h3, 1'b1);
      wr(ca(0, prd_pkg::OFS_VMIN), 32'h63, 1'b1);
      wr(ca(0, prd_pkg::OFS_VMIN), 32'h8CA1, 1'b1);
      wr(ca(0, prd_pkg::OFS_RATIO), 32'h68, 1'b1);
      wr(ca(0, prd_pkg::OFS_RATIO), 32'h1F5, 1'b1);
      wr(ca(0, prd_pkg::OFS_DELAY), 32'h9, 1'b1);
      wr(ca(0, prd_pkg::OFS_DELAY), 32'h1771, 1'b1);
      wr(prd_pkg::OFS_IRQ_STATUS, 32'h1, 1'b1);
      rd(12'hFFC, 32'h0, 1'b1);
      rd(ca(0, prd_pkg::OFS_VMIN), 32'h7D0, 1'b0);
      // defaults: card 0 wired reversed, card 1 standard, random volts
      wr(prd_pkg::OFS_IRQ_ENABLE, 32'h1, 1'b0);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         phaseMag[i*16+:16] <= 16'h07D1 + 16'(seed % 32'd30000);
      end
      actRev <= 2'h1;
      wait_flip(0, 1'b1, 500);
      repeat (2) @(posedge clock);
      `CHK("card 1 untouched", 1'b0, revInd[1])
      `CHK("irq raised", 1'b1, irq)
      rd(prd_pkg::OFS_IRQ_STATUS, 32'h1, 1'b0);
      wr(prd_pkg::OFS_IRQ_CLEAR, 32'h1, 1'b0);
      repeat (2) @(posedge clock);
      `CHK("irq cleared", 1'b0, irq)
      rd(prd_pkg::OFS_IRQ_STATUS, 32'h0, 1'b0);
      // swap back with the interrupt masked
      wr(prd_pkg::OFS_IRQ_ENABLE, 32'h0, 1'b0);
      actRev <= 2'h0;
      wait_flip(0, 1'b0, 500);
      repeat (2) @(posedge clock);
      `CHK("irq masked", 1'b0, irq)
      rd(prd_pkg::OFS_IRQ_STATUS, 32'h1, 1'b0);
      // threshold on card 1: equal to the minimum is not above it
      wr(ca(1, prd_pkg::OFS_DELAY), 32'hA, 1'b0);
      phaseMag[64+:16] <= 16'h07D0;
      actRev <= 2'h2;
      repeat (60) @(posedge clock);
      rd(ca(1, prd_pkg::OFS_STATE), 32'h0, 1'b0);
      phaseMag[64+:16] <= 16'h07D1;
      repeat (24) @(posedge clock);
      rd(ca(1, prd_pkg::OFS_STATE), 32'h6, 1'b0);
      phaseMag[64+:16] <= 16'h07D0;
      repeat (8) @(posedge clock);
      phaseMag[64+:16] <= 16'h07D1;
      wait_flip(1, 1'b1, 10);
      // ratio exactly at the limit does not start the timer
      wr(ca(1, prd_pkg::OFS_RATIO), 32'h78, 1'b0);
      ratioPct <= 9'h078;
      actRev <= 2'h0;
      repeat (60) @(posedge clock);
      rd(ca(1, prd_pkg::OFS_STATE), 32'h5, 1'b0);
      ratioPct <= 9'h079;
      wait_flip(1, 1'b0, 10);
      // fixed codes override detection
      wr(ca(1, prd_pkg::OFS_MODE), 32'h1, 1'b0);
      repeat (3) @(posedge clock);
      `CHK("forced reversed", 2'h2, revInd)
      repeat (60) @(posedge clock);
      rd(ca(1, prd_pkg::OFS_STATE), 32'h5, 1'b0);
      wr(ca(1, prd_pkg::OFS_MODE), 32'h0, 1'b0);
      repeat (3) @(posedge clock);
      `CHK("forced standard", 2'h3, stdInd)
      rd(ca(1, prd_pkg::OFS_MODE), 32'h0, 1'b0);
      repeat (4) @(posedge clock);
      `CHK("notes drained", 0, notes.size())
      finish_test();
   end
endmodule
